// ### rtl/lvds_display_serializer_consts.svh
// constants for the display link serializer
`ifndef LVDS_DISPLAY_SERIALIZER_CONSTS_SVH
`define LVDS_DISPLAY_SERIALIZER_CONSTS_SVH

`define WORD_WIDTH 21
`define COLOUR_WIDTH 6
`define LANE_COUNT 3
`define BITS_PER_LANE 7
`define SLOT_WIDTH 3
`define SLOT_LAST 3'h6
`define FWD_CLK_PATTERN 7'h63
`define SYS_CLK_HZ 40000000
`define LOCK_TIME_MS 10
`define LOCK_CYCLES_DEFAULT (`LOCK_TIME_MS * (`SYS_CLK_HZ / 1000))
`define LOCK_CNT_W 19

`endif

// ### rtl/lvds_display_serializer_pkg.sv
// types for the display link serializer
`default_nettype none
`include "lvds_display_serializer_consts.svh"

package lvds_display_serializer_pkg;

  typedef struct packed {
    logic [`COLOUR_WIDTH-1:0] red;
    logic [`COLOUR_WIDTH-1:0] green;
    logic [`COLOUR_WIDTH-1:0] blue;
    logic line_sync;
    logic frame_sync;
    logic pixel_valid;
  } pixel_word_t;

  typedef struct packed {
    logic [`LANE_COUNT-1:0] data;
    logic clk;
  } lanes_t;

  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic toggle;
    pixel_word_t word;
  } capture_state_t;

  typedef struct packed {
    logic sleep_meta;
    logic sleep_sync;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    pixel_word_t hold;
    logic [`SLOT_WIDTH-1:0] slot;
    logic [`WORD_WIDTH-1:0] shift_data;
    logic [`BITS_PER_LANE-1:0] shift_clk;
    logic [`LOCK_CNT_W-1:0] lock_cnt;
    logic locked;
    lanes_t lane_pos;
    lanes_t lane_neg;
    logic lanes_oe;
  } serial_state_t;

endpackage : lvds_display_serializer_pkg

`default_nettype wire

// ### rtl/pixel_capture.sv
// pixel-clock-side capture of the parallel word
`timescale 1ns/1ps
`default_nettype none

module pixel_capture
  import lvds_display_serializer_pkg::*;
(
  input wire logic clk_pixel_i,
  input wire logic rst_i,
  input wire pixel_word_t pixel_i,
  output logic toggle_o,
  output pixel_word_t word_o
);

  capture_state_t q, d;

  // =====================================================
  // next state
  always_comb begin
    d = q;
    d.rst_meta = rst_i;
    d.rst_sync = q.rst_meta;
    if (q.rst_sync) begin
      d.toggle = 1'b0;
      d.word = '0;
    end else begin
      d.word = pixel_i;  // see R1
      d.toggle = ~q.toggle;
    end
  end

  // =====================================================
  // falling edge strobe
  always_ff @(negedge clk_pixel_i) begin  // see R2
    q <= d;
  end

  assign toggle_o = q.toggle;
  assign word_o = q.word;

endmodule : pixel_capture

`default_nettype wire

// ### rtl/lvds_display_serializer.sv
// display link serializer: three data lanes and a forwarded clock lane
`timescale 1ns/1ps
`default_nettype none
`include "lvds_display_serializer_consts.svh"

// Overview of operation
// R1: parallel input is 21 bits: 18 colour bits, line sync, frame sync, valid.
// R2: whole parallel word is captured on each falling pixel clock edge.
// R3: word leaves on three serial data lanes plus a forwarded clock lane.
// R4: each data lane sends seven bits per pixel period, 21 in all.
// R5: bits 0 to 6 occupy seven successive equal slots of the period.
// R6: lanes are unreliable until lock time after clock or wake; lock is flagged.
// R7: while sleep_n is low all lanes, clock included, are high impedance.
// R8: high impedance is reached within 100 ns of sleep_n falling.
// R9: the pixel source may remap colours to inputs if the receiver matches.
// R10: fixed map: seven inputs per lane, bit 0 sent first each period.
module lvds_display_serializer
  import lvds_display_serializer_pkg::*;
#(
  parameter int LOCK_CYCLES = `LOCK_CYCLES_DEFAULT
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_pixel_i,
  input wire pixel_word_t pixel_i,
  input wire logic sleep_n_i,
  output lanes_t lane_pos_o,
  output lanes_t lane_neg_o,
  output logic lanes_oe_o,
  output logic locked_o
);

  // =====================================================
  // pixel clock domain
  logic cap_toggle;
  pixel_word_t cap_word;

  pixel_capture u_capture (
    .clk_pixel_i(clk_pixel_i),
    .rst_i(rst_i),
    .pixel_i(pixel_i),  // see R9
    .toggle_o(cap_toggle),
    .word_o(cap_word)
  );

  // =====================================================
  // serial domain state
  serial_state_t q, d;

  // =====================================================
  // per-lane shift and output bit
  wire logic [`WORD_WIDTH-1:0] data_shifted;
  wire logic [`LANE_COUNT-1:0] data_bit;

  for (genvar g = 0; g < `LANE_COUNT; g++) begin : g_lane
    assign data_shifted[g*`BITS_PER_LANE +: `BITS_PER_LANE] =
      {1'b0, q.shift_data[g*`BITS_PER_LANE+1 +: `BITS_PER_LANE-1]};  // see R4
    assign data_bit[g] = q.shift_data[g*`BITS_PER_LANE];  // see R3
  end

  // =====================================================
  // next state
  always_comb begin
    d = q;

    // wake and toggle synchronisers
    d.sleep_meta = sleep_n_i;
    d.sleep_sync = q.sleep_meta;
    d.tog_meta = cap_toggle;
    d.tog_sync = q.tog_meta;
    d.tog_seen = q.tog_sync;

    // new word: captured data has been stable since its toggle
    if (q.tog_sync != q.tog_seen) begin
      d.hold = cap_word;
    end

    // seven slots per period
    if (q.slot == `SLOT_LAST) begin  // see R5
      d.slot = '0;
    end else begin
      d.slot = q.slot + `SLOT_WIDTH'(1);
    end

    // shift each lane toward bit 0
    d.shift_data = data_shifted;
    d.shift_clk = {1'b0, q.shift_clk[`BITS_PER_LANE-1:1]};

    // reload at the end of each period
    if (q.slot == `SLOT_LAST) begin
      d.shift_data = d.hold;  // see R10
      d.shift_clk = `FWD_CLK_PATTERN;  // see R3
    end

    // lane drivers
    d.lane_pos = {data_bit, q.shift_clk[0]};
    d.lane_neg = ~d.lane_pos;
    d.lanes_oe = q.sleep_sync;

    // lock timer
    if (!q.locked) begin
      if (q.lock_cnt == `LOCK_CNT_W'(LOCK_CYCLES - 1)) begin  // see R6
        d.locked = 1'b1;
      end else begin
        d.lock_cnt = q.lock_cnt + `LOCK_CNT_W'(1);
      end
    end

    // sleep: lanes off, timer restarts
    if (!q.sleep_sync) begin  // see R7
      d.lanes_oe = 1'b0;  // see R8
      d.lane_pos = '0;
      d.lane_neg = '0;
      d.slot = '0;
      d.shift_data = '0;
      d.shift_clk = '0;
      d.lock_cnt = '0;
      d.locked = 1'b0;
    end
  end

  // =====================================================
  // registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lane_pos_o = q.lane_pos;
  assign lane_neg_o = q.lane_neg;
  assign lanes_oe_o = q.lanes_oe;
  assign locked_o = q.locked;

endmodule : lvds_display_serializer

`default_nettype wire

// ### test/ser_chk.sv
// port assertions for the display link serializer
`timescale 1ns/1ps
`default_nettype none
module ser_chk
  import lvds_display_serializer_pkg::*;
#(parameter int LOCK_CYCLES = 20) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sleep_n_i,
  input wire lanes_t lane_pos_o,
  input wire lanes_t lane_neg_o,
  input wire logic lanes_oe_o,
  input wire logic locked_o
);
  int n_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_sys_i) n_q <= (rst_i || !lanes_oe_o) ? 0 : n_q + 1;
  sequence s_low; !lane_pos_o.clk [*3]; endsequence
  sequence s_high; lane_pos_o.clk [*4]; endsequence
  chk_neg_inv: assert property (lanes_oe_o |-> lane_neg_o == ~lane_pos_o)
    else $error("neg lane");
  chk_clk_pattern: assert property (disable iff (rst_i || !lanes_oe_o)
    $fell(lane_pos_o.clk) |-> s_low ##1 s_high ##1 !lane_pos_o.clk) else $error("clk lane");
  chk_lock_time: assert property ($rose(locked_o) |->
    n_q >= LOCK_CYCLES - 1 && n_q <= LOCK_CYCLES + 1) else $error("lock time");
  chk_wake_unlocked: assert property ($rose(lanes_oe_o) |=> !locked_o [*8])
    else $error("early lock");
  chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    !lanes_oe_o && lane_pos_o == 0) else $error("reset lanes");
  chk_sleep_delay: assert property (!sleep_n_i [*3] |=> !lanes_oe_o)
    else $error("sleep late");
  chk_sleep_zero: assert property (!lanes_oe_o |->
    lane_pos_o == 0 && lane_neg_o == 0 && !locked_o) else $error("sleep lanes");
  chk_wake_drive: assert property (sleep_n_i [*6] |-> lanes_oe_o)
    else $error("no wake");
endmodule : ser_chk
`default_nettype wire

// ### test/lane_rx.sv
// display-side receiver model for the serial lanes
`timescale 1ns/1ps
`default_nettype none
module lane_rx
  import lvds_display_serializer_pkg::*;
(
  input wire logic clk_i,
  input wire lanes_t lane_i,
  input wire logic oe_i,
  input wire logic lock_i,
  output pixel_word_t word_o,
  output logic got_o
);
  logic [4:0] h_q;
  logic [6:0] d_q [3];
  // released data lanes read as the inverse of the last bit, the clock lane as 0
  always @(posedge clk_i) begin
    h_q <= {h_q[3:0], oe_i & lane_i.clk};
    for (int l = 0; l < 3; l++) d_q[l] <= {oe_i ? lane_i.data[l] : ~d_q[l][6], d_q[l][6:1]};
  end
  assign got_o = lock_i && h_q == 5'h03;
  assign word_o = {d_q[2], d_q[1], d_q[0]};
endmodule : lane_rx
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the display link serializer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lvds_display_serializer_pkg::*;
  localparam int LOCK_CYCLES = 20;
  logic clk_sys_i = 0, clk_pixel_i = 0, rst_i = 1, sleep_n_i = 1;
  logic lanes_oe_o, locked_o, rx_got;
  pixel_word_t pixel_i = '0, rx_w, last_w;
  lanes_t lane_pos_o, lane_neg_o;
  int miscompares = 0, n_tests = 0;
  logic [20:0] corners [4] = '{21'h1fffff, 21'h0, 21'h155555, 21'h100001};
  always #12.5 clk_sys_i = ~clk_sys_i;
  initial #7 forever #62.5 clk_pixel_i = ~clk_pixel_i;
  lvds_display_serializer #(.LOCK_CYCLES(LOCK_CYCLES)) i_dut (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .clk_pixel_i(clk_pixel_i), .pixel_i(pixel_i), .sleep_n_i(sleep_n_i),
    .lane_pos_o(lane_pos_o), .lane_neg_o(lane_neg_o), .lanes_oe_o(lanes_oe_o),
    .locked_o(locked_o));
  lane_rx i_rx (.clk_i(clk_sys_i), .lane_i(lane_pos_o), .oe_i(lanes_oe_o),
    .lock_i(locked_o), .word_o(rx_w), .got_o(rx_got));
  always @(posedge clk_sys_i) if (rx_got) last_w <= rx_w;
  function automatic logic [6:0] lane_bits(logic [20:0] w, int l);
    return w[7*l+:7];
  endfunction : lane_bits
  task automatic chk_lane(logic [6:0] got, logic [6:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_lane
  task automatic chk_state(logic [9:0] got, logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_state
  task automatic report_and_stop;
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic sleep_cycle;
    @(posedge clk_sys_i) sleep_n_i <= 0;
    repeat (3) @(posedge clk_sys_i);
    #1 chk_state({lanes_oe_o, locked_o, lane_pos_o, lane_neg_o}, 10'h000);
    repeat (11) @(posedge clk_sys_i);
    sleep_n_i <= 1;
    repeat (12) @(posedge clk_sys_i);
    #1 chk_state({lanes_oe_o, locked_o, 4'h0, lane_pos_o ^ lane_neg_o}, 10'h20f);
    repeat (20) @(posedge clk_sys_i);
    #1 chk_state({lanes_oe_o, locked_o, 4'h0, lane_pos_o ^ lane_neg_o}, 10'h30f);
  endtask : sleep_cycle
  initial begin
    #50us;
    miscompares++;
    report_and_stop();
  end
  initial begin
    logic [20:0] w;
    void'($urandom(32'h62dcb4b9));
    repeat (8) @(posedge clk_pixel_i);
    @(posedge clk_sys_i) rst_i <= 0;
    repeat (40) @(posedge clk_sys_i);
    for (int k = 0; k < 16; k++) begin
      w = k < 4 ? corners[k] : 21'($urandom);
      if (k == 8) sleep_cycle();
      @(posedge clk_pixel_i) pixel_i <= w;
      repeat (5) @(posedge clk_pixel_i);
      for (int l = 0; l < 3; l++)
        chk_lane(lane_bits(last_w, l), lane_bits(w, l));
    end
    report_and_stop();
  end
endmodule : testbench
bind lvds_display_serializer ser_chk #(.LOCK_CYCLES(LOCK_CYCLES)) i_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sleep_n_i(sleep_n_i), .lane_pos_o(lane_pos_o),
  .lane_neg_o(lane_neg_o), .lanes_oe_o(lanes_oe_o), .locked_o(locked_o));
`default_nettype wire
